/* rtl/led_drive_pkg.sv */
package led_drive_pkg;

   // Register offsets on the internal register port
   localparam logic [7:0] SINK_CURRENT_CONFIG_ADDR = 8'h43;
   localparam logic [7:0] OUTPUT_DRIVE_MODE_ADDR = 8'h44;
   localparam logic [7:0] SHARED_DUTY_LEVEL_ADDR = 8'h45;

   // Field positions and fixed bits of the sink current register
   localparam int SINK_FIELD_LSB = 0;
   localparam int SINK_FIELD_MSB = 1;
   localparam logic [1:0] SINK_FIXED_BITS = 2'h3;
   localparam logic [3:0] SINK_RSVD_BITS = 4'h0;

   // Values after reset
   localparam logic [1:0] SINK_CURRENT_RESET = 2'h0;
   localparam logic [7:0] OUTPUT_DRIVE_MODE_RESET = 8'h00;
   localparam logic [7:0] SHARED_DUTY_LEVEL_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Sink current levels in units of 10 uA
   localparam logic [10:0] SINK_5MA = 11'h1F4;
   localparam logic [10:0] SINK_6MA67 = 11'h29B;
   localparam logic [10:0] SINK_10MA = 11'h3E8;
   localparam logic [10:0] SINK_20MA = 11'h7D0;

   // Duty coding: the all-ones code means full on
   localparam logic [7:0] DUTY_FULL_CODE = 8'hFF;
   localparam logic [8:0] DUTY_FULL_STEPS = 9'h100;

   // Fade: sixteen equal steps; period codes 1..5 double from 256 ms
   localparam logic [4:0] FADE_STEPS = 5'h10;
   localparam logic [2:0] FADE_OFF = 3'h0;
   localparam logic [2:0] FADE_LONGEST = 3'h5;
   localparam int FADE_SHORTEST_MS = 256;
   localparam int CLK_KHZ = 250000;
   localparam int FADE_UNIT_CYCLES =
      (FADE_SHORTEST_MS / 16) * CLK_KHZ;

endpackage : led_drive_pkg

/* rtl/duty_modulator.sv */
`timescale 1ns/10ps
module duty_modulator
   import led_drive_pkg::*;
(
   // Clock, reset, enable
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // On-time in steps, 0 to 256
   input wire logic [8:0] on_steps_i,
   // Modulated drive level
   output logic pwm_on_o
);

   logic [7:0] step_q; // Position within the 256-step period

   // Free-running step counter; wraps every 256 enabled cycles
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         step_q <= 8'h00;
      else if (ce_i)
         step_q <= step_q + 8'h01;
   end

   // On while the step is below the on-time; 256 never turns off
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pwm_on_o <= 1'b0;
      else if (ce_i)
         pwm_on_o <= ({1'b0, step_q} < on_steps_i);
   end

   // Helper: on-cycles counted per period for the ratio check
   logic [8:0] on_cnt_q; // On-cycles seen since the period began
   logic [8:0] last_steps_q; // On-time of the previous enabled cycle
   logic [9:0] steady_q; // Enabled cycles the on-time stayed unchanged
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         on_cnt_q <= 9'h000;
         last_steps_q <= 9'h000;
         steady_q <= 10'h000;
      end
      else if (ce_i)
      begin
         last_steps_q <= on_steps_i;
         if (step_q == 8'h00)
            on_cnt_q <= {8'h00, pwm_on_o};
         else
            on_cnt_q <= on_cnt_q + {8'h00, pwm_on_o};
         // Saturates, so a long steady run never wraps to a false start
         if (on_steps_i != last_steps_q)
            steady_q <= 10'h000;
         else if (steady_q != 10'h3FF)
            steady_q <= steady_q + 10'h001;
      end
   end

   a_steady_no_gap: assert property (@(posedge mclk_i)
      disable iff (!rstn_i)
      ce_i && on_steps_i == DUTY_FULL_STEPS && $stable(on_steps_i)
      |=> pwm_on_o)
      else $error("Full duty dropped the output");

   a_zero_stays_off: assert property (@(posedge mclk_i)
      disable iff (!rstn_i)
      ce_i && on_steps_i == 9'h000 |=> !pwm_on_o)
      else $error("Zero duty drove the output");

   // The count lags the step by one cycle, so the on-time must have
   // stood still for a whole period plus a margin before it is judged
   a_ratio_count: assert property (@(posedge mclk_i)
      disable iff (!rstn_i)
      ce_i && step_q == 8'h00 && steady_q >= 10'h104
      |-> on_cnt_q == last_steps_q)
      else $error("On-time ratio wrong");

endmodule : duty_modulator

/* rtl/led_port_drive_and_common_duty.sv */
`timescale 1ns/10ps
module led_port_drive_and_common_duty
   import led_drive_pkg::*;
#(
   parameter int FADE_UNIT = FADE_UNIT_CYCLES
)
(
   // Clock, reset, enable
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // Register port from the serial interface engine
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Fade control from the configuration logic
   input wire logic [2:0] fade_time_i,
   input wire logic fade_in_i,
   // Open-drain port lines
   output logic [7:0] io_line_o,
   output logic [7:0] io_line_oe_o,
   // Analog sink controls
   output logic [7:0] const_current_en_o,
   output logic [1:0] sink_code_o,
   output logic [10:0] sink_level_10ua_o
);

   // Reset release synchroniser
   logic rst_meta_q;
   logic rst_sync_q;
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Map a duty code to on-steps; FF jumps to 256 so 255 never occurs
   function automatic logic [8:0] duty_steps(input logic [7:0] code);
      if (code == DUTY_FULL_CODE)
         return DUTY_FULL_STEPS;
      return {1'b0, code};
   endfunction : duty_steps

   // Decode the sink field into a level in 10 uA units
   function automatic logic [10:0] sink_level(input logic [1:0] code);
      unique case (code)
         2'h0: return SINK_5MA;
         2'h1: return SINK_6MA67;
         2'h2: return SINK_10MA;
         2'h3: return SINK_20MA;
      endcase
   endfunction : sink_level

   logic [1:0] sink_q; // Stored current field
   logic [7:0] mode_q; // Per-port drive mode
   logic [7:0] duty_q; // Shared duty code
   logic wr_hit; // Enabled write strobe
   assign wr_hit = ce_i && reg_wr_i;

   // Register writes; only the current field of 0x43 is stored
   always_ff @(posedge mclk_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         sink_q <= SINK_CURRENT_RESET;
         mode_q <= OUTPUT_DRIVE_MODE_RESET;
         duty_q <= SHARED_DUTY_LEVEL_RESET;
      end
      else if (wr_hit)
      begin
         // Fixed and reserved bits are dropped, so a host slip is harmless
         if (reg_addr_i == SINK_CURRENT_CONFIG_ADDR)
            sink_q <= reg_wdata_i[SINK_FIELD_MSB:SINK_FIELD_LSB];
         if (reg_addr_i == OUTPUT_DRIVE_MODE_ADDR)
            mode_q <= reg_wdata_i;
         if (reg_addr_i == SHARED_DUTY_LEVEL_ADDR)
            duty_q <= reg_wdata_i;
      end
   end

   // Registered read data, one cycle after the strobe
   always_ff @(posedge mclk_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         reg_rdata_o <= READ_UNMAPPED;
      else if (ce_i && reg_rd_i)
      begin
         unique case (reg_addr_i)
            SINK_CURRENT_CONFIG_ADDR:
               reg_rdata_o <= {SINK_FIXED_BITS, SINK_RSVD_BITS, sink_q};
            OUTPUT_DRIVE_MODE_ADDR:
               reg_rdata_o <= mode_q;
            SHARED_DUTY_LEVEL_ADDR:
               reg_rdata_o <= duty_q;
            default:
               reg_rdata_o <= READ_UNMAPPED; // Unmapped reads as zero
         endcase
      end
   end

   // Fade step interval: 1/16 of the period, doubling per code
   logic fade_on; // A defined fade period is selected
   logic [31:0] fade_interval;
   assign fade_on = fade_time_i != FADE_OFF && fade_time_i <= FADE_LONGEST;
   assign fade_interval = fade_on ?
      32'(FADE_UNIT) << (fade_time_i - 3'h1) : 32'h0000_0001;

   logic [4:0] level_q; // Fade level, 0 to 16 steps
   logic [31:0] timer_q; // Cycles within the current step
   logic [4:0] target; // Level the ramp heads for
   assign target = fade_in_i ? FADE_STEPS : 5'h00;

   // Fade ramp; without fading the level sits at full
   always_ff @(posedge mclk_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         level_q <= FADE_STEPS;
         timer_q <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         if (!fade_on)
         begin
            level_q <= FADE_STEPS;
            timer_q <= 32'h0000_0000;
         end
         else if (level_q == target)
            timer_q <= 32'h0000_0000; // Idle until direction changes
         else if (timer_q >= fade_interval - 32'h1)
         begin
            // One equal step toward the target
            timer_q <= 32'h0000_0000;
            level_q <= (level_q < target) ? level_q + 5'h01
                                          : level_q - 5'h01;
         end
         else
            timer_q <= timer_q + 32'h1;
      end
   end

   // Scale on-steps by the fade level; 16 of 16 leaves them whole
   logic [13:0] scaled;
   logic [8:0] on_steps;
   assign scaled = 14'(duty_steps(duty_q)) * 14'(level_q);
   assign on_steps = scaled[12:4];

   logic pwm_on; // Modulator output
   duty_modulator u_mod (
      .mclk_i(mclk_i),
      .rstn_i(rst_sync_q),
      .ce_i(ce_i),
      .on_steps_i(on_steps),
      .pwm_on_o(pwm_on)
   );

   // Port drive: open drain pulls low while the pulse is on
   always_ff @(posedge mclk_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         io_line_o <= 8'h00;
         io_line_oe_o <= 8'h00;
         const_current_en_o <= ~OUTPUT_DRIVE_MODE_RESET;
         sink_code_o <= SINK_CURRENT_RESET;
         sink_level_10ua_o <= SINK_5MA;
      end
      else if (ce_i)
      begin
         io_line_o <= 8'h00;
         io_line_oe_o <= {8{pwm_on}};
         const_current_en_o <= ~mode_q;
         sink_code_o <= sink_q;
         sink_level_10ua_o <= sink_level(sink_q);
      end
   end

   a_rsvd_read_back: assert property (@(posedge mclk_i)
      disable iff (!rst_sync_q)
      ce_i && reg_rd_i && reg_addr_i == SINK_CURRENT_CONFIG_ADDR
      |=> reg_rdata_o[7:2] == 6'h30)
      else $error("Fixed bits of current register wrong");

   a_sink_decode_20: assert property (@(posedge mclk_i)
      disable iff (!rst_sync_q)
      ce_i && sink_q == 2'h3 |=> sink_level_10ua_o == 11'h7D0)
      else $error("20 mA code decoded wrongly");

   a_mode_follows: assert property (@(posedge mclk_i)
      disable iff (!rst_sync_q)
      ce_i && wr_hit && reg_addr_i == OUTPUT_DRIVE_MODE_ADDR
      ##1 ce_i |=> const_current_en_o == ~$past(reg_wdata_i, 2))
      else $error("Drive mode did not follow write");

   a_duty_reset: assert property (@(posedge mclk_i)
      $rose(rst_sync_q) |-> duty_q == 8'h00 && !io_line_oe_o[0])
      else $error("Shared duty not zero after reset");

   // Full duty must still stand one cycle on, since the pulse seen on the
   // lines is the one the modulator launched then; a fade or a new duty
   // written in between would otherwise raise a false alarm
   a_full_on_lines: assert property (@(posedge mclk_i)
      disable iff (!rst_sync_q)
      ce_i && duty_q == 8'hFF && level_q == 5'h10
      ##1 ce_i && duty_q == 8'hFF && level_q == 5'h10
      ##1 ce_i |=> io_line_oe_o == 8'hFF)
      else $error("Full-on code left a gap");

   a_fade_step: assert property (@(posedge mclk_i)
      disable iff (!rst_sync_q)
      ce_i && $changed(level_q) && fade_on && $stable(fade_time_i)
      |-> (level_q - $past(level_q) == 5'h01)
          || ($past(level_q) - level_q == 5'h01))
      else $error("Fade moved more than one step");

endmodule : led_port_drive_and_common_duty

/* testbench/led_load.sv */
`timescale 1ns/10ps
// LED load on the open-drain lines, with pull-up resistors
module led_load
(
   // Clock and counting window
   input wire logic mclk_i,
   input wire logic clr_i,
   // Port lines as the block drives them
   input wire logic [7:0] line_i,
   input wire logic [7:0] line_oe_i,
   // Lit cycles of line 0 in the window
   output logic [8:0] lit_cnt_o
);
   logic [7:0] pad; // Released lines float up, never keep the old value
   assign pad = (line_oe_i & line_i) | ~line_oe_i;
   // LED lights while its pad is pulled low
   always_ff @(posedge mclk_i)
      if (clr_i)
         lit_cnt_o <= 9'h000;
      else if (!pad[0])
         lit_cnt_o <= lit_cnt_o + 9'h001;
endmodule : led_load

/* testbench/led_port_drive_and_common_duty_bench.sv */
`timescale 1ns/10ps
module led_port_drive_and_common_duty_bench;
   import led_drive_pkg::*;
   localparam int UNIT = 4; // Short fade unit keeps the run brief
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [2:0] ftime = 3'h0; // No fade to start with
   logic fin = 1'b0;
   logic clr = 1'b0;
   logic [7:0] rdata, line, line_oe, cc_en;
   logic [1:0] scode;
   logic [10:0] slevel;
   logic [8:0] lit;
   int fail_count = 0;
   int tests_run = 0;
   logic [10:0] lvl [4] = '{SINK_5MA, SINK_6MA67, SINK_10MA, SINK_20MA};
   logic [7:0] duty [5] = '{8'h01, 8'h02, 8'h7F, 8'hFE, 8'hFF};
   // Free-running clock
   always #2 mclk_i = ~mclk_i;
   led_port_drive_and_common_duty #(.FADE_UNIT(UNIT)) dut (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .fade_time_i(ftime), .fade_in_i(fin),
      .io_line_o(line), .io_line_oe_o(line_oe),
      .const_current_en_o(cc_en), .sink_code_o(scode),
      .sink_level_10ua_o(slevel));
   led_load leds (.mclk_i(mclk_i), .clr_i(clr), .line_i(line),
      .line_oe_i(line_oe), .lit_cnt_o(lit));
   // Compare and count
   task automatic chk(input string what, input logic [10:0] seen,
      input logic [10:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   // One register write, strobe held for one edge
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge mclk_i);
      wr = 1'b0;
   endtask : wr_reg
   // One register read, data taken after the answering edge
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk_i);
      rd = 1'b1;
      addr = a;
      @(negedge mclk_i);
      rd = 1'b0;
      d = rdata;
   endtask : rd_reg
   // Lit cycles over one full 256-step period
   task automatic measure(output logic [8:0] n);
      @(negedge mclk_i);
      clr = 1'b1;
      @(negedge mclk_i);
      clr = 1'b0;
      repeat (256) @(negedge mclk_i);
      n = lit;
   endtask : measure
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   // Main sequence
   initial
   begin
      logic [7:0] d;
      logic [8:0] n;
      repeat (20) @(negedge mclk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      chk("cc_en", {3'h0, cc_en}, 11'h0FF);
      chk("sink_level", slevel, SINK_5MA);
      rd_reg(8'h43, d);
      chk("rd43", {3'h0, d}, 11'h0C0);
      rd_reg(8'h44, d);
      chk("rd44", {3'h0, d}, 11'h000);
      rd_reg(8'h45, d);
      chk("rd45", {3'h0, d}, 11'h000);
      rd_reg(8'h46, d);
      chk("unmapped", {3'h0, d}, 11'h000);
      measure(n);
      chk("lit reset", {2'h0, n}, 11'h000);
      // Every current code, host keeping fixed and spare bits
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(8'h43, {6'h30, i[1:0]});
         rd_reg(8'h43, d);
         chk("rd43", {3'h0, d}, {5'h03, i[5:0]});
         chk("sink_code", {9'h000, scode}, i[10:0]);
         chk("sink_level", slevel, lvl[i]);
      end
      // Spare bits written anyway must not stick
      wr_reg(8'h43, 8'h3E);
      rd_reg(8'h43, d);
      chk("rd43 spare", {3'h0, d}, 11'h0C2);
      wr_reg(8'h44, 8'hA5);
      rd_reg(8'h44, d);
      chk("rd44", {3'h0, d}, 11'h0A5);
      chk("cc_en", {3'h0, cc_en}, 11'h05A);
      // Duty codes near both ends of the range, one mid-scale, and the full-on code
      for (int i = 0; i < 5; i++)
      begin
         wr_reg(8'h45, duty[i]);
         repeat (512) @(negedge mclk_i);
         measure(n);
         chk("lit", {2'h0, n},
            duty[i] == 8'hFF ? 11'h100 : {3'h0, duty[i]});
      end
      // Unmapped write leaves the duty alone
      wr_reg(8'h46, 8'h11);
      rd_reg(8'h45, d);
      chk("rd45", {3'h0, d}, 11'h0FF);
      // Fade out to dark, then back in to full duty
      @(negedge mclk_i);
      ftime = 3'h1;
      repeat (16 * UNIT + 600) @(negedge mclk_i);
      measure(n);
      chk("fade out", {2'h0, n}, 11'h000);
      fin = 1'b1;
      repeat (16 * UNIT + 600) @(negedge mclk_i);
      measure(n);
      chk("fade in", {2'h0, n}, 11'h100);
      finish_test();
   end
endmodule : led_port_drive_and_common_duty_bench
